//--- rtl/mdfm_pkg.sv
/*
 Constants, alarm codes and timing for the motor driver fault manager.
 Assumes a 25 MHz core clock and an external non-volatile history store.
*/
package mdfm_pkg;
	localparam int unsigned CLK_HZ = 25000000;
	// Blink on and off times, and the pause between groups, in milliseconds.
	localparam int unsigned BLINK_ON_MS = 200;
	localparam int unsigned BLINK_OFF_MS = 200;
	localparam int unsigned BLINK_GAP_MS = 1200;
	localparam int unsigned BLINK_ON_CYC = BLINK_ON_MS * (CLK_HZ / 1000);
	localparam int unsigned BLINK_OFF_CYC = BLINK_OFF_MS * (CLK_HZ / 1000);
	localparam int unsigned BLINK_GAP_CYC = BLINK_GAP_MS * (CLK_HZ / 1000);
	// Thresholds, in the units of the measurement inputs.
	localparam logic [15:0] OVER_VOLT_MV = 16'h9470;  // 38000 mV.
	localparam logic [15:0] UNDER_VOLT_MV = 16'h4650; // 18000 mV.
	localparam logic [15:0] OVER_SPEED_RPM = 16'h1450; // 5200 r/min.
	localparam logic [15:0] OVER_TEMP_C = 16'h0055;    // 85 degrees C.
	localparam int unsigned HIST_DEPTH = 10;
	localparam int unsigned CODE_W = 4;
	// Alarm codes equal the number of lamp blinks, except CODE_CPU, which lights the lamp steadily; 0 means none.
	localparam logic [3:0] CODE_NONE = 4'h0;
	localparam logic [3:0] CODE_OVERLOAD = 4'h2;
	localparam logic [3:0] CODE_SENSOR = 4'h3;
	localparam logic [3:0] CODE_OVERVOLT = 4'h4;
	localparam logic [3:0] CODE_UNDERVOLT = 4'h5;
	localparam logic [3:0] CODE_OVERSPEED = 4'h6;
	localparam logic [3:0] CODE_OVERCUR = 4'h7;
	localparam logic [3:0] CODE_DATA = 4'h8;
	localparam logic [3:0] CODE_OVERHEAT = 4'h9;
	localparam logic [3:0] CODE_EXTSTOP = 4'ha;
	localparam logic [3:0] CODE_POWERUP = 4'hb;
	localparam logic [3:0] CODE_CPU = 4'hf;
endpackage

//--- rtl/mdfm_history.sv
/*
 Ten-entry alarm history ring, newest first on read.
 Assumes the storage array is mapped onto non-volatile cells, so it has no reset.
*/
`timescale 1ns/1ps
`default_nettype none
module mdfm_history
	import mdfm_pkg::*;
#(
	parameter int unsigned DEPTH = HIST_DEPTH
) (
	// Clock and reset.
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Write side.
	input wire logic wr_en_in,
	input wire logic [3:0] wr_code_in,
	// Read side: index 0 is the newest entry.
	input wire logic [3:0] rd_idx_in,
	output logic [3:0] rd_code_out
);
	// The array and its head pointer live in retained storage: no reset on them.
	logic [3:0] mem_q [DEPTH];
	// A fresh part starts writing at slot zero; from then on the pointer is retained too.
	logic [3:0] head_q = 4'h0;
	logic [3:0] slot;

	// Writes are held off while reset is low, so a detector seen during power-up
	// is recorded once, when the latch really takes it.
	always_ff @(posedge clk_in) begin
		if (wr_en_in && rst_n_in) begin
			mem_q[head_q] <= wr_code_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (wr_en_in && rst_n_in) begin
			head_q <= (head_q >= 4'(DEPTH - 1)) ? 4'h0 : head_q + 4'h1;
		end
	end

	always_comb begin
		slot = (head_q > rd_idx_in) ? head_q - rd_idx_in - 4'h1
			: 4'(DEPTH) + head_q - rd_idx_in - 4'h1;
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rd_code_out <= 4'h0;
		end else begin
			rd_code_out <= (rd_idx_in < 4'(DEPTH)) ? mem_q[slot] : 4'h0;
		end
	end
endmodule
`default_nettype wire

//--- rtl/mdfm_blinker.sv
/*
 Lamp blink-code generator: code N gives N pulses then a long pause.
 Assumes the code input stands steady while an alarm is shown.
*/
`timescale 1ns/1ps
`default_nettype none
module mdfm_blinker
	import mdfm_pkg::*;
#(
	parameter int unsigned ON_CYC = BLINK_ON_CYC,
	parameter int unsigned OFF_CYC = BLINK_OFF_CYC,
	parameter int unsigned GAP_CYC = BLINK_GAP_CYC
) (
	// Clock and reset.
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Code to show and steady mode.
	input wire logic [3:0] code_in,
	input wire logic steady_in,
	// Lamp drive.
	output logic lamp_out
);
	typedef enum logic [1:0] {
		MDFM_BL_IDLE = 2'b00,
		MDFM_BL_ON = 2'b01,
		MDFM_BL_OFF = 2'b10,
		MDFM_BL_GAP = 2'b11
	} mdfm_bl_t;

	mdfm_bl_t state_q;
	logic [31:0] tmr_q;
	logic [3:0] cnt_q;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_q <= MDFM_BL_IDLE;
			tmr_q <= 32'h0;
			cnt_q <= 4'h0;
		end else if (steady_in || code_in == CODE_NONE) begin
			state_q <= MDFM_BL_IDLE;
			tmr_q <= 32'h0;
			cnt_q <= 4'h0;
		end else begin
			case (state_q)
				MDFM_BL_IDLE: begin
					state_q <= MDFM_BL_ON;
					tmr_q <= 32'(ON_CYC - 1);
					cnt_q <= 4'h1;
				end
				MDFM_BL_ON: begin
					if (tmr_q == 32'h0) begin
						state_q <= (cnt_q >= code_in) ? MDFM_BL_GAP : MDFM_BL_OFF;
						tmr_q <= (cnt_q >= code_in) ? 32'(GAP_CYC - 1) : 32'(OFF_CYC - 1);
					end else begin
						tmr_q <= tmr_q - 32'h1;
					end
				end
				MDFM_BL_OFF: begin
					if (tmr_q == 32'h0) begin
						state_q <= MDFM_BL_ON;
						tmr_q <= 32'(ON_CYC - 1);
						cnt_q <= cnt_q + 4'h1;
					end else begin
						tmr_q <= tmr_q - 32'h1;
					end
				end
				MDFM_BL_GAP: begin
					if (tmr_q == 32'h0) begin
						state_q <= MDFM_BL_ON;
						tmr_q <= 32'(ON_CYC - 1);
						cnt_q <= 4'h1;
					end else begin
						tmr_q <= tmr_q - 32'h1;
					end
				end
				default: begin
					state_q <= MDFM_BL_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			lamp_out <= 1'b0;
		end else begin
			lamp_out <= steady_in || (code_in != CODE_NONE && state_q == MDFM_BL_ON);
		end
	end
endmodule
`default_nettype wire

//--- rtl/mdfm_fault_manager.sv
/*
 Top of the motor driver fault manager: latches alarms, gates the motor,
 drives the alarm outputs and lamp, and records alarms in the history.
 Assumes all inputs are synchronous to clk_in and rst_n_in is power-on reset.
*/
`timescale 1ns/1ps
`default_nettype none
module mdfm_fault_manager
	import mdfm_pkg::*;
#(
	parameter int unsigned OVERLOAD_CYC = 32'd25000000,
	parameter int unsigned ON_CYC = BLINK_ON_CYC,
	parameter int unsigned OFF_CYC = BLINK_OFF_CYC,
	parameter int unsigned GAP_CYC = BLINK_GAP_CYC
) (
	// Clock and reset.
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Host operation and clear inputs.
	input wire logic run_request_in,
	input wire logic direction_select_in,
	input wire logic fault_clear_in,
	input wire logic external_fault_in,
	// Configuration tool commands and settings.
	input wire logic tool_reset_in,
	input wire logic tool_stop_in,
	input wire logic powerup_guard_en_in,
	// Measurements and detector flags.
	input wire logic over_torque_in,
	input wire logic sensor_ok_in,
	input wire logic [15:0] supply_mv_in,
	input wire logic [15:0] speed_rpm_in,
	input wire logic over_current_in,
	input wire logic data_corrupt_in,
	input wire logic [15:0] temp_c_in,
	input wire logic cpu_fail_in,
	// History read port.
	input wire logic [3:0] hist_idx_in,
	output logic [3:0] hist_code_out,
	// Motor drive.
	output logic drive_en_out,
	output logic drive_dir_out,
	output logic brake_out,
	// Alarm outputs.
	output logic alarm_out_normally_open,
	output logic alarm_out_normally_closed,
	output logic power_fault_lamp,
	output logic [3:0] alarm_code_out
);
	logic clear_d_q;
	logic first_q;
	logic [31:0] ovl_cnt_q;
	logic [3:0] code_q;
	logic [3:0] new_code;
	logic clear_edge;
	logic reset_req;
	logic latched;
	logic hard;

	// Highest-severity detector wins when several fire together.
	always_comb begin
		new_code = CODE_NONE;
		if (first_q && powerup_guard_en_in && run_request_in) new_code = CODE_POWERUP;
		if (!external_fault_in || tool_stop_in) new_code = CODE_EXTSTOP;
		if (ovl_cnt_q >= 32'(OVERLOAD_CYC)) new_code = CODE_OVERLOAD;
		if (speed_rpm_in > OVER_SPEED_RPM) new_code = CODE_OVERSPEED;
		if (supply_mv_in < UNDER_VOLT_MV) new_code = CODE_UNDERVOLT;
		if (supply_mv_in > OVER_VOLT_MV) new_code = CODE_OVERVOLT;
		if (!sensor_ok_in) new_code = CODE_SENSOR;
		if (temp_c_in > OVER_TEMP_C) new_code = CODE_OVERHEAT;
		if (data_corrupt_in) new_code = CODE_DATA;
		if (over_current_in) new_code = CODE_OVERCUR;
		if (cpu_fail_in) new_code = CODE_CPU;
	end

	assign latched = (code_q != CODE_NONE);
	assign hard = (code_q == CODE_OVERCUR) || (code_q == CODE_DATA) || (code_q == CODE_CPU);
	assign clear_edge = fault_clear_in && !clear_d_q;
	assign reset_req = (clear_edge || tool_reset_in) && !run_request_in && !hard;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			clear_d_q <= 1'b0;
			first_q <= 1'b1;
		end else begin
			clear_d_q <= fault_clear_in;
			first_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ovl_cnt_q <= 32'h0;
		end else if (!over_torque_in) begin
			ovl_cnt_q <= 32'h0;
		end else if (ovl_cnt_q < 32'(OVERLOAD_CYC)) begin
			ovl_cnt_q <= ovl_cnt_q + 32'h1;
		end
	end

	// A new alarm wins over a reset in the same cycle, so the earlier code stays latched (CODE_CPU replaces it) and the new one is not recorded.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			code_q <= CODE_NONE;
		end else if (!latched && new_code != CODE_NONE) begin
			code_q <= new_code;
		end else if (latched && code_q != CODE_CPU && new_code == CODE_CPU) begin
			code_q <= CODE_CPU;
		end else if (latched && reset_req && new_code == CODE_NONE) begin
			code_q <= CODE_NONE;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			drive_en_out <= 1'b0;
			drive_dir_out <= 1'b0;
			brake_out <= 1'b0;
		end else begin
			drive_en_out <= run_request_in && !latched && new_code == CODE_NONE;
			drive_dir_out <= direction_select_in;
			brake_out <= 1'b0;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			alarm_out_normally_open <= 1'b0;
			alarm_out_normally_closed <= 1'b0;
			alarm_code_out <= CODE_NONE;
		end else begin
			alarm_out_normally_open <= latched;
			alarm_out_normally_closed <= !latched;
			alarm_code_out <= code_q;
		end
	end

	mdfm_history #(
		.DEPTH(HIST_DEPTH)
	) u_hist (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.wr_en_in(!latched && new_code != CODE_NONE),
		.wr_code_in(new_code),
		.rd_idx_in(hist_idx_in),
		.rd_code_out(hist_code_out)
	);

	mdfm_blinker #(
		.ON_CYC(ON_CYC),
		.OFF_CYC(OFF_CYC),
		.GAP_CYC(GAP_CYC)
	) u_blink (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.code_in(code_q == CODE_CPU ? CODE_NONE : code_q),
		.steady_in(code_q == CODE_CPU),
		.lamp_out(power_fault_lamp)
	);

	AST_NO_DRIVE_IN_ALARM: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		latched |=> !drive_en_out) else $error("drive enabled while alarm latched");
	AST_ALARM_OUTS: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		latched |=> alarm_out_normally_open && !alarm_out_normally_closed)
		else $error("alarm outputs wrong");
	AST_NO_BRAKE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		latched |=> !brake_out) else $error("brake applied on alarm");
	AST_HARD_HOLD: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		hard |=> latched) else $error("hard alarm cleared");
	AST_RUN_BLOCKS_RESET: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(latched && run_request_in) |=> latched) else $error("reset taken while running");
	AST_LEVEL_NO_CLEAR: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(latched && fault_clear_in && clear_d_q && !tool_reset_in) |=> latched)
		else $error("cleared on level");
	AST_EDGE_CLEARS: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(reset_req && latched && new_code == CODE_NONE) |=> !latched)
		else $error("reset not taken");
	AST_OVERVOLT: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(!latched && supply_mv_in > OVER_VOLT_MV && new_code == CODE_OVERVOLT)
		|=> code_q == CODE_OVERVOLT) else $error("overvoltage not latched");
	AST_CPU_STEADY: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(code_q == CODE_CPU) [*2] |=> power_fault_lamp) else $error("lamp not steady");
endmodule
`default_nettype wire

//--- verif/mdfm_host_model.sv
/*
 Host controller model: drives the run, direction and clear lines.
 Assumes a free-running clk_in; all changes land 1 ns after its edge.
*/
`timescale 1ns/1ps
`default_nettype none
module mdfm_host_model (
	// Clock and driver feedback.
	input wire logic clk_in,
	input wire logic drive_in,
	// Host outputs.
	output logic run_out,
	output logic dir_out,
	output logic clear_out
);
	initial begin
		run_out = 1'b0;
		dir_out = 1'b0;
		clear_out = 1'b0;
	end
	task automatic set(input logic run, input logic clr);
		@(posedge clk_in);
		// A clear is only raised once drive has gone, as a stand-in for a stopped shaft.
		while (clr && !clear_out && drive_in) @(posedge clk_in);
		#1;
		run_out = run;
		clear_out = clr;
		dir_out = 1'($urandom);
	endtask
endmodule
`default_nettype wire

//--- verif/tb_motor_driver_fault_manager.sv
/*
 Testbench for the fault manager: alarm latching, clearing and history.
 Assumes short overload and blink counts set through the parameters.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_motor_driver_fault_manager import mdfm_pkg::*;;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic run, dir, clr, ext, trst, tstop, guard, torq, sok, oc, dc, cpu;
	logic den, ddir, brk, no, nc, lamp;
	logic [15:0] supply, speed, temp;
	logic [3:0] hidx, hcode, acode;
	logic [10:0] exp_q[$];
	logic [7:0] lamp_hi;
	logic [3:0] hist_q[$];
	logic [3:0] codes[10] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'ha};
	int n_mismatch = 0;
	int checks_done = 0;
	event chk;
	always #20 clk_in = ~clk_in;
	mdfm_host_model host (.clk_in(clk_in), .drive_in(den), .run_out(run), .dir_out(dir),
		.clear_out(clr));
	mdfm_fault_manager #(.OVERLOAD_CYC(10), .ON_CYC(4), .OFF_CYC(4), .GAP_CYC(12)) dut (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .run_request_in(run),
		.direction_select_in(dir), .fault_clear_in(clr), .external_fault_in(ext),
		.tool_reset_in(trst), .tool_stop_in(tstop), .powerup_guard_en_in(guard),
		.over_torque_in(torq), .sensor_ok_in(sok), .supply_mv_in(supply),
		.speed_rpm_in(speed), .over_current_in(oc), .data_corrupt_in(dc),
		.temp_c_in(temp), .cpu_fail_in(cpu), .hist_idx_in(hidx), .hist_code_out(hcode),
		.drive_en_out(den), .drive_dir_out(ddir), .brake_out(brk),
		.alarm_out_normally_open(no), .alarm_out_normally_closed(nc),
		.power_fault_lamp(lamp), .alarm_code_out(acode));
	task automatic stop_test();
		if (n_mismatch == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	task automatic cmp(input string name, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (e !== g) begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", name, e, g);
		end
	endtask
	// Status is {open, closed, drive, brake, code}; brake must never engage.
	task automatic expect_st(input logic en, input logic [3:0] code);
		exp_q.push_back({3'd0, code != 4'h0, code == 4'h0, en, 1'b0, code});
		exp_q.push_back({3'd2, 7'h0, dir});
		->chk;
	endtask
	// One blink period is n on-times and n-1 off-times of 4 cycles plus a 12-cycle pause,
	// so any window of that length holds exactly n on-times of lit lamp.
	task automatic expect_blinks(input logic [3:0] n);
		lamp_hi = 8'h0;
		repeat (8 * int'(n) + 8) begin
			lamp_hi += 8'(lamp);
			cyc(1);
		end
		exp_q.push_back({3'd3, 8'(4 * int'(n))});
		->chk;
	endtask
	task automatic expect_h(input logic [3:0] idx, input logic [3:0] code);
		hidx = idx;
		cyc(2);
		exp_q.push_back({3'd1, 4'h0, code});
		->chk;
	endtask
	// Several notes may be queued in one time step, so drain the queue on each wake-up.
	always @(chk) begin
		logic [10:0] e;
		while (exp_q.size() > 0) begin
			e = exp_q.pop_front();
			case (e[10:8])
				3'd0: cmp("status", e[7:0], {no, nc, den, brk, acode});
				3'd1: cmp("history", e[7:0], {4'h0, hcode});
				3'd2: cmp("direction", e[7:0], {7'h0, ddir});
				3'd3: cmp("blinks", e[7:0], lamp_hi);
				default: cmp("lamp", e[7:0], {7'h0, lamp});
			endcase
		end
	end
	// Off values sit exactly on each threshold, which must not trip.
	task automatic set_cause(input int k, input logic on);
		case (k)
			0: torq = on;
			1: sok = !on;
			2: supply = on ? 16'h9471 : 16'h9470;
			3: supply = on ? 16'h464f : 16'h4650;
			4: speed = on ? 16'h1451 : 16'h1450;
			5: oc = on;
			6: dc = on;
			7: temp = on ? 16'h0056 : 16'h0055;
			8: ext = !on;
			10: cpu = on;
			default: tstop = on;
		endcase
	endtask
	task automatic power_cycle(input logic r);
		host.set(r, 1'b0);
		rst_n_in = 1'b0;
		cyc(2);
		rst_n_in = 1'b1;
		cyc(3);
	endtask
	initial begin
		void'($urandom(10));
		{ext, sok} = 2'b11;
		{trst, tstop, torq, oc, dc, cpu} = 6'h00;
		// Run is low at the first release, so the guard setting must not matter there.
		guard = 1'($urandom);
		hidx = 4'h0;
		supply = 16'h4650 + 16'($urandom_range(0, 20000));
		speed = 16'($urandom_range(0, 5200));
		temp = 16'($urandom_range(0, 85));
		repeat (10) @(posedge clk_in);
		#1;
		rst_n_in = 1'b1;
		cyc(2);
		for (int k = 0; k < 10; k++) begin
			host.set(1'b1, 1'b0);
			cyc(2);
			expect_st(1'b1, 4'h0);
			set_cause(k, 1'b1);
			cyc(k == 0 ? 16 : 3);
			expect_st(1'b0, codes[k]);
			expect_blinks(codes[k]);
			hist_q.push_front(codes[k]);
			set_cause(k, 1'b0);
			host.set(1'b1, 1'b1);
			cyc(3);
			expect_st(1'b0, codes[k]);
			host.set(1'b0, 1'b1);
			cyc(3);
			expect_st(1'b0, codes[k]);
			host.set(1'b0, 1'b0);
			if (k == 3) begin
				trst = 1'(k == 3);
				cyc(1);
				trst = 1'b0;
			end else begin
				host.set(1'b0, 1'b1);
			end
			cyc(3);
			expect_st(1'b0, (k == 5 || k == 6) ? codes[k] : 4'h0);
			if (k == 5 || k == 6)
				power_cycle(1'b0);
		end
		guard = 1'b1;
		power_cycle(1'b1);
		expect_st(1'b0, 4'hb);
		expect_blinks(4'hb);
		hist_q.push_front(4'hb);
		host.set(1'b0, 1'b0);
		host.set(1'b0, 1'b1);
		guard = 1'b0;
		cyc(3);
		expect_st(1'b0, 4'h0);
		set_cause(10, 1'b1);
		cyc(3);
		expect_st(1'b0, 4'hf);
		hist_q.push_front(4'hf);
		repeat (8) begin
			cyc(1);
			exp_q.push_back(11'h401);
			->chk;
		end
		set_cause(10, 1'b0);
		host.set(1'b0, 1'b0);
		host.set(1'b0, 1'b1);
		cyc(3);
		expect_st(1'b0, 4'hf);
		power_cycle(1'b0);
		expect_st(1'b0, 4'h0);
		while (hist_q.size() > 10) void'(hist_q.pop_back());
		for (int i = 0; i < 11; i++)
			expect_h(4'(i), i < 10 ? hist_q[i] : 4'h0);
		cyc(2);
		stop_test();
	end
	// The whole sequence, blink windows included, needs about a thousand cycles.
	initial begin
		repeat (3000) @(posedge clk_in);
		n_mismatch++;
		stop_test();
	end
endmodule
`default_nettype wire
